// ===== core/bas_defines.vh
`ifndef BAS_DEFINES_VH
`define BAS_DEFINES_VH
`define BAS_BCD_LIMIT 4'h9
`define BAS_BCD_FIX 4'h6
`define BAS_Q1 4'h1
`define BAS_Q2 4'h2
`define BAS_Q3 4'h4
`define BAS_Q4 4'h8
`define BAS_ACC_RESET 8'h00
`endif

// ===== core/bas_core.v
// How it works
// (RULE1) low nibble gets plus six when over nine
// (RULE2) high nibble plus digit carry, maybe six
// (RULE3) accumulator raw BCD sum becomes packed BCD
// (RULE4) compare skip: one word, one or two cycles
// (RULE5) skipping two-word instruction takes three cycles
// (RULE6) skip cycles do nothing in all quarters
// (RULE7) skip next instruction when register below accumulator
// (RULE8) unsigned subtract decides less, flush fetched word
// (RULE9) adjust single cycle, read Q2, write Q4, carry only
`timescale 1ns/10ps
`include "bas_defines.vh"
module bas_core (
	input wire i_clock,
	input wire i_nrst,
	input wire i_ce,
	input wire i_start,
	input wire i_is_daw,
	input wire i_is_cmp,
	input wire [7:0] i_acc,
	input wire [7:0] i_reg_op,
	input wire i_carry,
	input wire i_digit_carry_flag,
	input wire i_next_two_word,
	output reg [3:0] o_phase,
	output reg o_busy,
	output reg o_acc_we,
	output reg [7:0] o_acc_wdata,
	output reg o_carry_we,
	output reg o_carry,
	output reg o_skip,
	output reg o_flush,
	output reg o_done
);
	localparam ST_IDLE = 4'h1;
	localparam ST_DAW = 4'h2;
	localparam ST_CMP = 4'h4;
	localparam ST_NOP = 4'h8;

	reg [3:0] state_reg;
	reg [3:0] phase_reg;
	reg [7:0] opa_reg;
	reg [7:0] opb_reg;
	reg dc_reg;
	reg c_reg;
	reg two_word_reg;
	reg [1:0] nop_left_reg;
	wire [8:0] adj;
	wire less;
	reg [3:0] state_next;
	reg [3:0] phase_next;
	reg [7:0] opa_next;
	reg [7:0] opb_next;
	reg dc_next;
	reg c_next;
	reg two_word_next;
	reg [1:0] nop_left_next;
	reg [3:0] phase_out_next;
	reg busy_next;
	reg acc_we_next;
	reg [7:0] acc_wdata_next;
	reg carry_we_next;
	reg carry_next;
	reg skip_next;
	reg flush_next;
	reg done_next;

	// decimal adjust, ninth bit becomes the carry out
	function [8:0] bcd_adjust;
		input [7:0] a;
		input dc;
		input c;
		reg [4:0] lo;
		reg [4:0] hi;
		begin
			lo = {1'b0, a[3:0]};
			if (a[3:0] > `BAS_BCD_LIMIT || dc) begin // RULE1
				lo = lo + {1'b0, `BAS_BCD_FIX};
			end
			hi = {1'b0, a[7:4]} + {4'h0, dc};
			if (hi > {1'b0, `BAS_BCD_LIMIT} || c) begin // RULE2
				hi = hi + {1'b0, `BAS_BCD_FIX};
			end
			bcd_adjust = {hi, lo[3:0]}; // RULE3
		end
	endfunction

	// next quarter; wraps around so the phase stays one-hot
	function [3:0] next_quarter;
		input [3:0] q;
		begin
			next_quarter = {q[2:0], q[3]};
		end
	endfunction

	assign adj = bcd_adjust(opa_reg, dc_reg, c_reg);
	// unsigned subtraction borrow means register is below accumulator
	wire [8:0] diff = {1'b0, opb_reg} - {1'b0, opa_reg}; // RULE8
	assign less = diff[8];

	// pulses default low, levels hold until a state changes them
	always @* begin
		state_next = state_reg;
		phase_next = phase_reg;
		opa_next = opa_reg;
		opb_next = opb_reg;
		dc_next = dc_reg;
		c_next = c_reg;
		two_word_next = two_word_reg;
		nop_left_next = nop_left_reg;
		phase_out_next = phase_reg;
		busy_next = o_busy;
		acc_we_next = 1'b0;
		acc_wdata_next = o_acc_wdata;
		carry_we_next = 1'b0;
		carry_next = o_carry;
		skip_next = o_skip;
		flush_next = o_flush;
		done_next = 1'b0;
		case (state_reg)
		ST_IDLE: begin
			busy_next = 1'b0;
			flush_next = 1'b0;
			skip_next = 1'b0;
			phase_next = `BAS_Q1;
			if (i_start && (i_is_daw || i_is_cmp)) begin
				// adjust wins when both kinds are asked for at once
				state_next = i_is_daw ? ST_DAW : ST_CMP;
				two_word_next = i_next_two_word;
				busy_next = 1'b1;
				phase_next = `BAS_Q2;
			end
		end
		ST_DAW: begin
			phase_next = next_quarter(phase_reg);
			// operands are captured in the read quarter; later changes are ignored
			if (phase_reg == `BAS_Q2) begin // RULE9
				opa_next = i_acc;
				dc_next = i_digit_carry_flag;
				c_next = i_carry;
			end
			if (phase_reg == `BAS_Q4) begin // RULE9
				acc_we_next = 1'b1;
				acc_wdata_next = adj[7:0]; // RULE3
				// only carry is touched; it may set, never cleared
				carry_we_next = 1'b1;
				carry_next = adj[8] | c_reg;
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
		end
		ST_CMP: begin
			phase_next = next_quarter(phase_reg);
			if (phase_reg == `BAS_Q2) begin
				opa_next = i_acc;
				opb_next = i_reg_op;
			end
			if (phase_reg == `BAS_Q4) begin
				// no write back in Q4; decide the skip
				skip_next = less; // RULE7
				if (less) begin
					state_next = ST_NOP; // RULE4
					nop_left_next = two_word_reg ? 2'h2 : 2'h1; // RULE5
				end else begin
					done_next = 1'b1; // RULE4
					state_next = ST_IDLE;
				end
			end
		end
		ST_NOP: begin
			// flushed cycle: every quarter is a no operation
			flush_next = 1'b1; // RULE6
			phase_next = next_quarter(phase_reg);
			if (phase_reg == `BAS_Q4) begin
				nop_left_next = nop_left_reg - 2'h1;
				if (nop_left_reg == 2'h1) begin // RULE5
					done_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
		end
		default: begin
			state_next = ST_IDLE;
			phase_next = `BAS_Q1;
		end
		endcase
	end

	// all state, outputs included, freezes while the enable is low
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= ST_IDLE;
			phase_reg <= `BAS_Q1;
			opa_reg <= `BAS_ACC_RESET;
			opb_reg <= `BAS_ACC_RESET;
			dc_reg <= 1'b0;
			c_reg <= 1'b0;
			two_word_reg <= 1'b0;
			nop_left_reg <= 2'h0;
			o_phase <= `BAS_Q1;
			o_busy <= 1'b0;
			o_acc_we <= 1'b0;
			o_acc_wdata <= `BAS_ACC_RESET;
			o_carry_we <= 1'b0;
			o_carry <= 1'b0;
			o_skip <= 1'b0;
			o_flush <= 1'b0;
			o_done <= 1'b0;
		end else if (i_ce) begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			opa_reg <= opa_next;
			opb_reg <= opb_next;
			dc_reg <= dc_next;
			c_reg <= c_next;
			two_word_reg <= two_word_next;
			nop_left_reg <= nop_left_next;
			o_phase <= phase_out_next;
			o_busy <= busy_next;
			o_acc_we <= acc_we_next;
			o_acc_wdata <= acc_wdata_next;
			o_carry_we <= carry_we_next;
			o_carry <= carry_next;
			o_skip <= skip_next;
			o_flush <= flush_next;
			o_done <= done_next;
		end
	end
endmodule

// ===== verification/bas_core_checker.sv
`timescale 1ns/10ps
module bas_core_checker(input wire i_clock,i_nrst,i_ce,i_start,i_is_daw,i_is_cmp,i_carry,i_digit_carry_flag,
	i_next_two_word,o_busy,o_acc_we,o_carry_we,o_carry,o_flush,o_skip,o_done,
	input wire [7:0] i_acc,i_reg_op,o_acc_wdata,input wire [3:0] o_phase);
	wire g=i_ce&&i_start&&!o_busy;
	wire ad=g&&i_is_daw;
	wire cm=g&&i_is_cmp&&!i_is_daw;
	wire lt=i_reg_op<i_acc;
	wire [4:0] h=i_acc[7:4]+i_digit_carry_flag;
	wire cx=i_carry|(h>5'h09);
	wire [7:0] ex={h[3:0]+(h>5'h09||i_carry?4'h6:4'h0),i_acc[3:0]+(i_acc[3:0]>4'h9||i_digit_carry_flag?4'h6:4'h0)};
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	a_adjust_timing: assert property (ad|->##4 o_done&&o_acc_we&&o_carry_we) else $error("adjust late");
	a_adjust_early: assert property (ad|=>!o_done[*3]) else $error("adjust early");
	a_adjust_value: assert property (ad|->##4 o_acc_wdata==$past(ex,3)) else $error("adjust value");
	a_adjust_carry: assert property (ad|->##4 o_carry==$past(cx,3)) else $error("adjust carry");
	a_cmp_noskip: assert property (cm&&!lt|->##4 o_done&&!o_skip) else $error("compare");
	a_skip_one: assert property (cm&&lt&&!i_next_two_word|->##4 o_skip##1 o_flush[*3]##1 o_done) else $error("skip");
	a_skip_two: assert property (cm&&lt&&i_next_two_word|->##4 o_skip##1 o_flush[*7]##1 o_done) else $error("skip2");
	a_flush_quiet: assert property (o_flush|->!o_acc_we&&!o_carry_we) else $error("flush write");
	a_phase_onehot: assert property ($onehot(o_phase)) else $error("phase not one-hot");
	a_busy_hold: assert property (g&&(i_is_daw||i_is_cmp)|=>o_busy[*4]) else $error("busy dropped");
	c_adjust: cover property (ad);
	c_noskip: cover property (cm&&!lt);
	c_skip_two: cover property (cm&&lt&&i_next_two_word);
endmodule
bind bas_core bas_core_checker i_chk(.*);

// ===== verification/bas_core_tb.sv
`timescale 1ns/10ps
module bas_core_tb;
	reg i_clock=0,i_nrst=0,i_ce=1,i_start=0,i_is_daw=0,i_is_cmp=0,i_carry=0,i_digit_carry_flag=0,i_next_two_word=0;
	reg [7:0] i_acc=0,i_reg_op=0;
	wire [3:0] o_phase;
	wire [7:0] o_acc_wdata;
	wire o_busy,o_acc_we,o_carry_we,o_carry,o_skip,o_flush,o_done;
	integer n_errors=0,total_checks=0,i,n,lo,hi,w;
	bas_core i_dut(.*);
	initial forever #12.5 i_clock=~i_clock;
	task chk(input [7:0] s,e);
		begin
			total_checks=total_checks+1;
			if(s!==e) begin
				n_errors=n_errors+1;
				$display("wrong value at %0t: %h not %h",$time,s,e);
			end
		end
	endtask
	task print_verdict;
		begin
			if(n_errors==0&&total_checks>0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// gap before each start lets busy and skip fall back first
	task run(input d,input [7:0] a,r);
		begin
			repeat(3) @(posedge i_clock);
			#2 i_is_daw=d;
			i_is_cmp=d?$urandom:1;
			i_acc=a;
			i_reg_op=r;
			i_start=1;
			@(posedge i_clock);
			#2 i_start=0;
			n=1;
			while(o_done!==1&&n<20) begin
				@(posedge i_clock);
				#2 n=n+1;
			end
			if(n>=20) begin
				n_errors=n_errors+1;
				print_verdict;
			end
		end
	endtask
	initial begin
		n=$urandom(59518);
		repeat(6) @(posedge i_clock);
		#2 i_nrst=1;
		for(i=0;i<60;i=i+1) begin
			i_digit_carry_flag=$urandom;
			i_carry=$urandom;
			run(1,i?$urandom:8'ha5,$urandom);
			lo=i_acc%16;
			hi=i_acc/16+i_digit_carry_flag;
			if(lo>9||i_digit_carry_flag)
				lo=lo+6;
			chk(o_carry,i_carry|hi>9);
			if(hi>9||i_carry)
				hi=hi+6;
			chk(n,4);
			chk(o_acc_wdata,hi%16*16+lo%16);
			chk(o_acc_we&o_carry_we,1);
			chk(o_phase,8);
		end
		for(i=0;i<60;i=i+1) begin
			i_next_two_word=$urandom;
			w=$urandom%256;
			run(0,w,i<6?w:$urandom);
			chk(n,i_reg_op<i_acc?(i_next_two_word?12:8):4);
			chk(o_skip,i_reg_op<i_acc);
			chk(o_flush,i_reg_op<i_acc);
			chk(o_acc_we|o_carry_we,0);
			chk(o_phase,8);
			chk(o_busy,1);
		end
		print_verdict;
	end
endmodule
